// File: gmp_defines.vh
/*
 Constants for the gigabit mode and pattern test control registers:
 management register numbers, control word fields and reset value,
 8b/10b character codes and management frame counts.
 Assumes inclusion by bare name from the design files of this block.
*/
`ifndef GMP_DEFINES_VH
`define GMP_DEFINES_VH

// ==========================================================
// Register numbers (5-bit management register address)
`define GMP_REG_RSVD_A 5'h17
`define GMP_REG_CTRL 5'h18
`define GMP_REG_RSVD_B 5'h19
`define GMP_REG_STAT0 5'h1A
`define GMP_REG_STAT1 5'h1B
`define GMP_REG_STAT2 5'h1C
`define GMP_REG_TEST 5'h1F

// ==========================================================
// Control word layout and reset value
`define GMP_CTRL_RST 16'h100C
`define GMP_B_GIGE 15
`define GMP_B_BUSY 14
`define GMP_B_CTC 12
`define GMP_B_VE 9
`define GMP_B_GEN 8
`define GMP_B_EMPH_HI 3
`define GMP_B_EMPH_LO 2
`define GMP_ZERO16 16'h0000

// ==========================================================
// Characters, decoded byte form with a separate K flag
`define GMP_K28_5 8'hBC
`define GMP_D10_1 8'h2A
`define GMP_D15_2 8'h4F
`define GMP_D5_6 8'hC5

// ==========================================================
// Channels and management frame counts
`define GMP_NCH 8
`define GMP_PHY_ADDR 5'h00
`define GMP_PRE_LEN 6'h20
`define GMP_HDR_LAST 6'h0C
`define GMP_DATA_LAST 6'h0F
`define GMP_CNT_ZERO 6'h00
`define GMP_CNT_ONE 6'h01
`define GMP_OP_RD 2'h2
`define GMP_OP_WR 2'h1

`endif

// File: gmp_mdio_slave.v
/*
 Management frame engine: clause 22 style serial frames on mdc/mdio,
 decoded into register reads and one-cycle register write strobes.
 Assumes mdc is far slower than clk (at least 8 clk per mdc phase);
 both pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gmp_defines.vh"

module gmp_mdio_slave #(
  parameter [4:0] PHY_ADDR = `GMP_PHY_ADDR
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Management pins
  input wire mdc,
  input wire mdio_in,
  output wire mdio_out,
  output wire mdio_oe,
  // Register side
  output wire [4:0] reg_addr,
  output wire reg_wr,
  output wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata
);

  localparam [1:0] ST_PRE = 2'h0;
  localparam [1:0] ST_HDR = 2'h1;
  localparam [1:0] ST_TA = 2'h2;
  localparam [1:0] ST_DATA = 2'h3;

  reg mdc_s1_q, mdc_s2_q, mdc_s3_q, mdio_s1_q, mdio_s2_q;
  reg [1:0] st_q;
  reg [5:0] cnt_q;
  reg [15:0] sh_q;
  reg [15:0] wdata_q;
  reg [4:0] addr_q;
  reg rd_q, oe_q, out_q, wr_q;
  wire rise;
  wire [1:0] op;

  // ==========================================================
  // Pin synchronisers; edge taken only after the second stage
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdc_s1_q <= 1'b0;
      mdc_s2_q <= 1'b0;
      mdc_s3_q <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end
    else
    begin
      mdc_s1_q <= mdc;
      mdc_s2_q <= mdc_s1_q;
      mdc_s3_q <= mdc_s2_q;
      mdio_s1_q <= mdio_in;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  assign rise = mdc_s2_q & ~mdc_s3_q;
  assign op = sh_q[10:9];

  // ==========================================================
  // Frame sequencer; drives after rising mdc so the station
  // samples stable data on its next rising edge
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_PRE;
      cnt_q <= `GMP_CNT_ZERO;
      sh_q <= `GMP_ZERO16;
      wdata_q <= `GMP_ZERO16;
      addr_q <= 5'h00;
      rd_q <= 1'b0;
      oe_q <= 1'b0;
      out_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      wr_q <= 1'b0;
      if (rise)
      begin
        case (st_q)
          ST_PRE:
          begin
            // Count ones; a zero after a full preamble starts a frame
            if (mdio_s2_q)
            begin
              if (cnt_q != `GMP_PRE_LEN)
                cnt_q <= cnt_q + `GMP_CNT_ONE;
            end
            else if (cnt_q == `GMP_PRE_LEN)
            begin
              st_q <= ST_HDR;
              cnt_q <= `GMP_CNT_ZERO;
            end
            else
              cnt_q <= `GMP_CNT_ZERO;
          end
          ST_HDR:
          begin
            sh_q <= {sh_q[14:0], mdio_s2_q};
            cnt_q <= cnt_q + `GMP_CNT_ONE;
            if (cnt_q == `GMP_HDR_LAST)
            begin
              cnt_q <= `GMP_CNT_ZERO;
              // Foreign address or bad opcode: stay quiet
              if (sh_q[11] && sh_q[8:4] == PHY_ADDR &&
                  (op == `GMP_OP_RD || op == `GMP_OP_WR))
              begin
                st_q <= ST_TA;
                rd_q <= (op == `GMP_OP_RD);
                addr_q <= {sh_q[3:0], mdio_s2_q};
              end
              else
                st_q <= ST_PRE;
            end
          end
          ST_TA:
          begin
            if (cnt_q == `GMP_CNT_ZERO)
            begin
              cnt_q <= `GMP_CNT_ONE;
              oe_q <= rd_q;
              out_q <= 1'b0;
            end
            else
            begin
              st_q <= ST_DATA;
              cnt_q <= `GMP_CNT_ZERO;
              sh_q <= reg_rdata;
              out_q <= reg_rdata[15];
            end
          end
          ST_DATA:
          begin
            sh_q <= {sh_q[14:0], mdio_s2_q};
            out_q <= sh_q[14];
            cnt_q <= cnt_q + `GMP_CNT_ONE;
            if (cnt_q == `GMP_DATA_LAST)
            begin
              st_q <= ST_PRE;
              cnt_q <= `GMP_CNT_ZERO;
              oe_q <= 1'b0;
              out_q <= 1'b0;
              wr_q <= ~rd_q;
              wdata_q <= {sh_q[14:0], mdio_s2_q};
            end
          end
          default:
            st_q <= ST_PRE;
        endcase
      end
    end
  end

  assign mdio_out = out_q;
  assign mdio_oe = oe_q;
  assign reg_addr = addr_q;
  assign reg_wr = wr_q;
  assign reg_wdata = wdata_q;

endmodule // gmp_mdio_slave
`default_nettype wire

// File: gmp_ctrl_regs.v
/*
 Gigabit mode and pattern test control word with its reserved
 neighbours, reached over the management pins, plus the per-channel
 idle recognition and idle disparity correction that the word steers.
 Assumes the datapath side (characters, pass results) runs on clk;
 the two mode pins and the management pins are asynchronous.
*/
// Operation
// - Receive K28.5 plus data char is idle
// - Transmit idle pair swaps D15.2 for D5.6
// - Gigabit mode is register bit OR pin
// - Busy on passes K28.5/D10.1 as data
// - Busy setting is register bit OR pin
// - Busy handling only in gigabit mode
// - Check enable; receive passes in upper byte
// - Generate enable; transmit passes in lower byte
// - Two-bit emphasis level, resets to high
// - Reserved control bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "gmp_defines.vh"

module gmp_ctrl_regs (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Management pins
  input wire mdc,
  input wire mdio_in,
  output wire mdio_out,
  output wire mdio_oe,
  // Mode pins
  input wire gige_idle_mode_pin,
  input wire busy_passthrough_pin,
  // Global settings to the channels
  output wire gige_mode_active,
  output wire busy_sequence_select,
  output wire clock_tolerance_comp_enable,
  output wire rx_pattern_check_enable,
  output wire pattern_generate_enable,
  output wire [1:0] global_emphasis_level,
  // Pattern pass results from the channels
  input wire [7:0] rx_pattern_pass,
  input wire [7:0] tx_pattern_pass,
  // Receive characters in, idle marks out
  input wire [63:0] rx_char,
  input wire [7:0] rx_char_k,
  output wire [7:0] rx_idle,
  // Transmit characters in and out
  input wire [63:0] tx_char,
  input wire [7:0] tx_char_k,
  output wire [63:0] tx_char_out,
  output wire [7:0] tx_char_k_out
);

  reg gige_bit_q, busy_bit_q, ctc_q, ve_q, gen_q;
  reg [1:0] emph_q;
  reg gpin_s1_q, gpin_s2_q, bpin_s1_q, bpin_s2_q;
  reg gige_eff_q, busy_eff_q;
  reg [15:0] rdata;
  reg [7:0] rx_k28_q, rx_idle_q, tx_k28_q, tx_k_q;
  reg [63:0] tx_out_q;
  wire [4:0] reg_addr;
  wire reg_wr;
  wire [15:0] reg_wdata;
  wire [15:0] ctrl_word;
  localparam [15:0] ctrl_rst = `GMP_CTRL_RST;

  // Reset image is a constant, so the reset branch loads constants only

  // ==========================================================
  // Management frame engine
  gmp_mdio_slave u_mdio (
    .clk(clk),
    .rst_n(rst_n),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(rdata)
  );

  // ==========================================================
  // Control word; only the defined fields have storage, so
  // reserved bits cannot hold a written value
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gige_bit_q <= ctrl_rst[`GMP_B_GIGE];
      busy_bit_q <= ctrl_rst[`GMP_B_BUSY];
      ctc_q <= ctrl_rst[`GMP_B_CTC];
      ve_q <= ctrl_rst[`GMP_B_VE];
      gen_q <= ctrl_rst[`GMP_B_GEN];
      emph_q <= ctrl_rst[`GMP_B_EMPH_HI:`GMP_B_EMPH_LO];
    end
    else if (reg_wr && reg_addr == `GMP_REG_CTRL)
    begin
      gige_bit_q <= reg_wdata[`GMP_B_GIGE];
      busy_bit_q <= reg_wdata[`GMP_B_BUSY];
      ctc_q <= reg_wdata[`GMP_B_CTC];
      ve_q <= reg_wdata[`GMP_B_VE];
      gen_q <= reg_wdata[`GMP_B_GEN];
      emph_q <= reg_wdata[`GMP_B_EMPH_HI:`GMP_B_EMPH_LO];
    end
  end

  // Readback image with reserved positions forced low
  assign ctrl_word = {gige_bit_q, busy_bit_q, 1'b0, ctc_q,
                      2'b00, ve_q, gen_q, 4'h0, emph_q, 2'b00};

  // ==========================================================
  // Read mux; reserved words and unknown registers answer zero
  always @*
  begin
    case (reg_addr)
      `GMP_REG_CTRL: rdata = ctrl_word;
      `GMP_REG_TEST: rdata = {rx_pattern_pass, tx_pattern_pass};
      `GMP_REG_RSVD_A, `GMP_REG_RSVD_B, `GMP_REG_STAT0,
      `GMP_REG_STAT1, `GMP_REG_STAT2: rdata = `GMP_ZERO16;
      default: rdata = `GMP_ZERO16;
    endcase
  end

  // ==========================================================
  // Mode pins pass two flops before use; the effective
  // settings are registered to keep fan-out off the sync path
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gpin_s1_q <= 1'b0;
      gpin_s2_q <= 1'b0;
      bpin_s1_q <= 1'b0;
      bpin_s2_q <= 1'b0;
      gige_eff_q <= 1'b0;
      busy_eff_q <= 1'b0;
    end
    else
    begin
      gpin_s1_q <= gige_idle_mode_pin;
      gpin_s2_q <= gpin_s1_q;
      bpin_s1_q <= busy_passthrough_pin;
      bpin_s2_q <= bpin_s1_q;
      gige_eff_q <= gige_bit_q | gpin_s2_q;
      // Busy is masked outside gigabit mode
      busy_eff_q <= (busy_bit_q | bpin_s2_q) &
                    (gige_bit_q | gpin_s2_q);
    end
  end

  assign gige_mode_active = gige_eff_q;
  assign busy_sequence_select = busy_eff_q;
  assign clock_tolerance_comp_enable = ctc_q;
  assign rx_pattern_check_enable = ve_q;
  assign pattern_generate_enable = gen_q;
  assign global_emphasis_level = emph_q;

  // ==========================================================
  // Per-channel idle handling, one cycle of latency each way
  genvar ch;
  generate
    for (ch = 0; ch < `GMP_NCH; ch = ch + 1)
    begin : g_ch
      wire [7:0] rc;
      wire [7:0] tc;
      assign rc = rx_char[ch*8 +: 8];
      assign tc = tx_char[ch*8 +: 8];

      // Receive: comma then a data character marks idle, except D10.1 with busy on
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          rx_k28_q[ch] <= 1'b0;
          rx_idle_q[ch] <= 1'b0;
        end
        else
        begin
          rx_k28_q[ch] <= rx_char_k[ch] & (rc == `GMP_K28_5);
          rx_idle_q[ch] <= gige_eff_q & rx_k28_q[ch] &
                           ~rx_char_k[ch] &
                           ~(busy_eff_q & (rc == `GMP_D10_1));
        end
      end

      // Transmit: swap the second idle character to fix disparity
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          tx_k28_q[ch] <= 1'b0;
          tx_k_q[ch] <= 1'b0;
          tx_out_q[ch*8 +: 8] <= 8'h00;
        end
        else
        begin
          tx_k28_q[ch] <= tx_char_k[ch] & (tc == `GMP_K28_5);
          tx_k_q[ch] <= tx_char_k[ch];
          if (gige_eff_q && tx_k28_q[ch] && !tx_char_k[ch] &&
              tc == `GMP_D15_2)
            tx_out_q[ch*8 +: 8] <= `GMP_D5_6;
          else
            tx_out_q[ch*8 +: 8] <= tc;
        end
      end
    end
  endgenerate

  assign rx_idle = rx_idle_q;
  assign tx_char_out = tx_out_q;
  assign tx_char_k_out = tx_k_q;

endmodule // gmp_ctrl_regs
`default_nettype wire

// File: gmp_ctrl_regs_asserts.sv
/*
 Checker: gigabit mode pin, busy masking, idle marks, idle fix-up and reset values.
 Assumes binding to gmp_ctrl_regs; lane 0 stands for every lane.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gmp_defines.vh"

module gmp_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Modes
  input wire logic gige_idle_mode_pin,
  input wire logic gige_mode_active,
  input wire logic busy_sequence_select,
  input wire logic clock_tolerance_comp_enable,
  input wire logic [1:0] global_emphasis_level,
  // Characters
  input wire logic [63:0] rx_char,
  input wire logic [7:0] rx_char_k,
  input wire logic [7:0] rx_idle,
  input wire logic [63:0] tx_char,
  input wire logic [7:0] tx_char_k,
  input wire logic [63:0] tx_char_out,
  input wire logic [7:0] tx_char_k_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========
  // Lane 0 character classes
  wire logic ge = gige_mode_active;
  wire logic rx_comma = rx_char_k[0] && rx_char[7:0] == `GMP_K28_5;
  wire logic rx_data = !rx_char_k[0];
  wire logic rx_busy = busy_sequence_select && rx_char[7:0] == `GMP_D10_1;
  wire logic tx_comma = tx_char_k[0] && tx_char[7:0] == `GMP_K28_5;
  wire logic tx_d15 = !tx_char_k[0] && tx_char[7:0] == `GMP_D15_2;
  // ==========
  // Modes; pins pass two syncs, so allow a few cycles
  property p_gige_pin; gige_idle_mode_pin [*6] |-> ge;
  endproperty
  a_gige_pin: assert property (p_gige_pin)
    else $error("gigabit mode missed its pin");
  property p_busy_mask; busy_sequence_select |-> ge;
  endproperty
  a_busy_mask: assert property (p_busy_mask)
    else $error("busy handling outside gigabit mode");
  property p_rst_val; $rose(rst_n) |->
    clock_tolerance_comp_enable && global_emphasis_level == 2'h3;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("wrong settings after reset");
  // ==========
  // Receive idle marks
  property p_rx_idle; (ge && rx_comma) ##1 (ge && rx_data && !rx_busy)
    |=> rx_idle[0];
  endproperty
  a_rx_idle: assert property (p_rx_idle)
    else $error("idle pair not marked");
  property p_busy_data; (ge && rx_comma) ##1 (ge && rx_data && rx_busy)
    |=> !rx_idle[0];
  endproperty
  a_busy_data: assert property (p_busy_data)
    else $error("busy pair marked as idle");
  property p_no_gige; !ge [*2] |=> rx_idle == 8'h00;
  endproperty
  a_no_gige: assert property (p_no_gige)
    else $error("idle marked outside gigabit mode");
  // ==========
  // Transmit idle fix-up
  property p_tx_fix; (ge && tx_comma) ##1 (ge && tx_d15)
    |=> tx_char_out[7:0] == `GMP_D5_6 && !tx_char_k_out[0];
  endproperty
  a_tx_fix: assert property (p_tx_fix)
    else $error("idle pair not corrected");
  property p_tx_pass; !ge [*3] |=> tx_char_out == $past(tx_char)
    && tx_char_k_out == $past(tx_char_k);
  endproperty
  a_tx_pass: assert property (p_tx_pass)
    else $error("transmit char altered outside gigabit mode");
  // Main scenarios
  c_rx_idle: cover property ((ge && rx_comma) ##1 rx_data);
  c_tx_fix: cover property ((ge && tx_comma) ##1 tx_d15);
  c_busy: cover property ((ge && rx_comma) ##1 (rx_data && rx_busy));
endmodule // gmp_chk

bind gmp_ctrl_regs gmp_chk gmp_chk_inst (
  .clk(clk), .rst_n(rst_n), .gige_idle_mode_pin(gige_idle_mode_pin),
  .gige_mode_active(gige_mode_active),
  .busy_sequence_select(busy_sequence_select),
  .clock_tolerance_comp_enable(clock_tolerance_comp_enable),
  .global_emphasis_level(global_emphasis_level),
  .rx_char(rx_char), .rx_char_k(rx_char_k), .rx_idle(rx_idle),
  .tx_char(tx_char), .tx_char_k(tx_char_k), .tx_char_out(tx_char_out),
  .tx_char_k_out(tx_char_k_out));
`default_nettype wire

// File: gmp_station.sv
/*
 Management station model: whole frames on mdc and the mdio wire.
 Assumes clk at 250 MHz; each mdc phase lasts half clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gmp_defines.vh"

module gmp_station (
  // Clock
  input wire logic clk,
  // Device drive on the wire
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // Pins toward the device
  output var logic mdc,
  output wire logic mdio_in
);
  int half = 10;
  logic drv_en = 1'b0;
  logic drv = 1'b1;
  // Released wire floats to the pull-up, never to a stale bit
  assign mdio_in = drv_en ? drv : (mdio_oe ? mdio_out : 1'b1);
  initial mdc = 1'b0;

  // One frame with its own preamble; reads let go from turnaround
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--)
    begin
      drv_en = !(op == `GMP_OP_RD && i < 18);
      drv = bits[i];
      repeat (half) @(negedge clk);
      if (i < 16)
        rd[i] = mdio_in;
      mdc = 1'b1;
      repeat (half) @(negedge clk);
      mdc = 1'b0;
    end
    drv_en = 1'b0;
  endtask
endmodule // gmp_station
`default_nettype wire

// File: tb_gige_mode_prbs_control_regs.sv
/*
 Testbench: management reads and writes, mode pins, idle marks
 and idle fix-up on all lanes. Assumes gmp_station as the host.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gmp_defines.vh"

module tb_gige_mode_prbs_control_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mdc, mdio_in, mdio_out, mdio_oe, gige_mode_active;
  logic gige_idle_mode_pin = 1'b0;
  logic busy_passthrough_pin = 1'b0;
  logic busy_sequence_select, clock_tolerance_comp_enable;
  logic rx_pattern_check_enable, pattern_generate_enable;
  logic [1:0] global_emphasis_level, lv;
  logic [63:0] rx_char = 64'h0;
  logic [63:0] tx_char = 64'h0;
  logic [63:0] tx_char_out;
  logic [7:0] rx_char_k = 8'h00;
  logic [7:0] tx_char_k = 8'h00;
  logic [7:0] rx_idle, tx_char_k_out;
  logic [15:0] rd;
  logic [4:0] rsv [5] = '{`GMP_REG_RSVD_A, `GMP_REG_RSVD_B,
    `GMP_REG_STAT0, `GMP_REG_STAT1, `GMP_REG_STAT2};
  int err_total = 0;
  int checked = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  gmp_ctrl_regs gmp_ctrl_regs_inst (
    .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .gige_idle_mode_pin(gige_idle_mode_pin),
    .busy_passthrough_pin(busy_passthrough_pin),
    .gige_mode_active(gige_mode_active),
    .busy_sequence_select(busy_sequence_select),
    .clock_tolerance_comp_enable(clock_tolerance_comp_enable),
    .rx_pattern_check_enable(rx_pattern_check_enable),
    .pattern_generate_enable(pattern_generate_enable),
    .global_emphasis_level(global_emphasis_level),
    .rx_pattern_pass(8'h5A), .tx_pattern_pass(8'h3C),
    .rx_char(rx_char), .rx_char_k(rx_char_k), .rx_idle(rx_idle),
    .tx_char(tx_char), .tx_char_k(tx_char_k), .tx_char_out(tx_char_out),
    .tx_char_k_out(tx_char_k_out));

  gmp_station gmp_station_inst (
    .clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
    .mdio_in(mdio_in));

  // ==========
  // Shared tasks
  task automatic tally_and_finish;
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    gmp_station_inst.frame(`GMP_OP_WR, `GMP_PHY_ADDR, ra, wd, rd);
  endtask

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    gmp_station_inst.frame(`GMP_OP_RD, `GMP_PHY_ADDR, ra, 16'h0000, rd);
    chk(rd, exp);
  endtask

  // Comma then one data char on every lane; results show at return
  task automatic pair(input logic [7:0] d);
    rx_char_k = 8'hFF;
    tx_char_k = 8'hFF;
    rx_char = {8{`GMP_K28_5}};
    tx_char = {8{`GMP_K28_5}};
    @(negedge clk);
    rx_char_k = 8'h00;
    tx_char_k = 8'h00;
    rx_char = {8{d}};
    tx_char = {8{d}};
    @(negedge clk);
  endtask

  // Hang guard; the full run needs about 35000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      tally_and_finish;
    end
  end

  // ==========
  // Main sequence
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk(clock_tolerance_comp_enable, 1'b1);
    chk(global_emphasis_level, 2'h3);
    rd_chk(`GMP_REG_CTRL, `GMP_CTRL_RST);
    wr(`GMP_REG_CTRL, 16'hFFFF);
    rd_chk(`GMP_REG_CTRL, 16'hD30C);
    chk({gige_mode_active, busy_sequence_select}, 2'h3);
    chk({rx_pattern_check_enable, pattern_generate_enable}, 2'h3);
    rd_chk(`GMP_REG_TEST, 16'h5A3C);
    for (int i = 0; i < 4; i++)
    begin
      lv = i;
      wr(`GMP_REG_CTRL, {12'h000, lv, 2'h0});
      chk(global_emphasis_level, lv);
      chk(clock_tolerance_comp_enable, 1'b0);
    end
    // Slow station; a foreign address must leave the word alone
    gmp_station_inst.half = 13;
    gmp_station_inst.frame(`GMP_OP_WR, 5'h01, `GMP_REG_CTRL, 16'hFFFF, rd);
    gmp_station_inst.frame(2'h3, `GMP_PHY_ADDR, `GMP_REG_CTRL, 16'hFFFF, rd);
    rd_chk(`GMP_REG_CTRL, 16'h000C);
    for (int i = 0; i < 5; i++)
    begin
      wr(rsv[i], 16'hFFFF);
      rd_chk(rsv[i], 16'h0000);
    end
    // Pins: busy alone is ignored, with gigabit mode it counts
    busy_passthrough_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk(busy_sequence_select, 1'b0);
    pair(`GMP_D15_2);
    chk(rx_idle, 8'h00);
    chk(tx_char_out, {8{`GMP_D15_2}});
    gige_idle_mode_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk({gige_mode_active, busy_sequence_select}, 2'h3);
    pair(`GMP_D10_1);
    chk(rx_idle, 8'h00);
    pair(`GMP_D15_2);
    chk(rx_idle, 8'hFF);
    chk(tx_char_out, {8{`GMP_D5_6}});
    chk(tx_char_k_out, 8'h00);
    busy_passthrough_pin = 1'b0;
    repeat (6) @(negedge clk);
    pair(`GMP_D10_1);
    chk(rx_idle, 8'hFF);
    gige_idle_mode_pin = 1'b0;
    wr(`GMP_REG_CTRL, 16'h400C);
    chk(busy_sequence_select, 1'b0);
    wr(`GMP_REG_CTRL, 16'hC00C);
    chk({gige_mode_active, busy_sequence_select}, 2'h3);
    tally_and_finish;
  end
endmodule // tb_gige_mode_prbs_control_regs
`default_nettype wire
